// >>> output_force_disarm_control_tb.sv
// self-checking bench for ovr_ctrl over apb.
// assumes the checker is bound and the load model is the far side.
`timescale 1ns/1ns
`default_nettype none
module output_force_disarm_control_tb
  import ovr_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic boot_done, prot_running;
  logic [11:0] paddr, ab;
  logic [31:0] pwdata, prdata, rdv;
  logic [1:0] rot_calc, rot_set;
  logic [n_out-1:0] out_normal, out_latched, out_hold_run, relay_out;
  logic [n_out-1:0] latch_cmd;
  logic health_green, rot_mismatch, reboot_req;
  logic [ana_w-1:0] live [n_ana];
  logic [ana_w-1:0] val [n_ana];
  int checked, miscompares, n, k;
  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  ovr_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .out_normal, .out_latched,
    .out_hold_run, .boot_done, .prot_running, .rot_calc, .rot_set,
    .temp_live(live[0]), .aout_assigned(live[1]), .ain_live(live[2]),
    .relay_out, .health_green, .rot_mismatch, .reboot_req,
    .temp_value(val[0]), .aout_value(val[1]), .ain_value(val[2]));
  relay_load_model load (.pclk, .presetn, .relay_out, .latch_cmd,
    .out_latched, .out_hold_run);
  // *****
  // tasks
  // *****
  task test_done;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      miscompares++;
      test_done();
    end
    rdv = prdata;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdv, e);
  endtask
  task cyc(input int c);
    repeat (c) @(posedge pclk);
  endtask
  // sample registered outputs mid-cycle, then realign to the rising edge
  task rchk(input logic [7:0] e);
    @(negedge pclk);
    chk({24'h0, relay_out}, {24'h0, e});
    @(posedge pclk);
  endtask
  task vchk(input int i, input logic [15:0] e);
    @(negedge pclk);
    chk({16'h0, val[i]}, {16'h0, e});
    @(posedge pclk);
  endtask
  // *****
  // sequence
  // *****
  initial begin
    psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    out_normal = 0; boot_done = 0; prot_running = 0; latch_cmd = 0;
    rot_calc = 0; rot_set = 0; presetn = 0;
    checked = 0; miscompares = 0;
    for (k = 0; k < n_ana; k++) live[k] = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    boot_done <= 1;
    prot_running <= 1;
    rot_calc <= 2'h1;
    cyc(6);
    chk({30'h0, health_green, rot_mismatch}, 32'h3);
    prot_running <= 0;
    rot_set <= 2'h1;
    cyc(6);
    chk({30'h0, health_green, rot_mismatch}, 32'h0);
    wr(a_ctrl, 32'h1);
    n = 0;
    while (reboot_req !== 1'b1 && n < 30) begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, reboot_req}, 32'h1);
    wr(12'h0fc, 32'hffffffff);
    rdc(12'h0fc, 32'h0);
    wr(a_frc_tmo, 32'h8);
    wr(a_frc_val, 32'hff);
    wr(a_frc_single, 32'h4);
    cyc(2);
    rchk(8'h04);
    cyc(16);
    rchk(8'h00);
    wr(a_frc_single, 32'h6);
    cyc(20);
    rchk(8'h06);
    wr(a_frc_grp, 32'h0002_0303);
    cyc(2);
    rchk(8'hf0);
    wr(a_frc_grp, 32'h0);
    cyc(2);
    rchk(8'h06);
    wr(a_frc_single, 32'h0);
    cyc(2);
    rchk(8'h00);
    out_normal <= 8'hff;
    wr(a_dis_ctrl, 32'hb);
    cyc(2);
    rchk(8'h0f);
    wr(a_dis_ctrl, 32'hf);
    cyc(2);
    rchk(8'h03);
    out_normal <= 8'h00;
    wr(a_frc_single, 32'he);
    cyc(2);
    rchk(8'h02);
    wr(a_frc_single, 32'h0);
    wr(a_dis_ctrl, 32'h0);
    out_normal <= 8'hff;
    latch_cmd <= 8'hf0;
    cyc(4);
    wr(a_dis_ctrl, 32'hb);
    cyc(4);
    rchk(8'hff);
    wr(a_dis_ctrl, 32'h0);
    latch_cmd <= 8'h00;
    cyc(4);
    wr(a_dis_ctrl, 32'h3);
    cyc(4);
    rchk(8'hff);
    wr(a_dis_ctrl, 32'h0);
    wr(a_dis_tmo, 32'h8);
    wr(a_dis_ctrl, 32'h9);
    cyc(2);
    rchk(8'h0f);
    cyc(16);
    rchk(8'hff);
    for (k = 0; k < n_ana; k++) begin
      ab = a_ana_base + 12'(k) * ana_stride;
      live[k] <= 16'(16'h1230 + k);
      cyc(2);
      rdc(ab + ana_view, 32'h1230 + k);
      wr(ab + ana_tmo, 32'hc);
      wr(ab + ana_val, 32'habcd);
      wr(ab + ana_ctrl, 32'h1);
      live[k] <= 16'(16'h5a50 + k);
      vchk(k, 16'habcd);
      rdc(ab + ana_view, 32'h1230 + k);
      cyc(20);
      vchk(k, 16'(16'h5a50 + k));
      rdc(ab + ana_view, 32'h5a50 + k);
    end
    test_done();
  end
endmodule
`default_nettype wire

// >>> ovr_ctrl.sv
// service override logic: output forcing, group disarm, analog forcing.
// assumes apb master on pclk; status inputs are synchronous to pclk
// except phase/boot/protection/latch/hold pins which are synchronised here.
//
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module ovr_ctrl
  import ovr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [n_out-1:0] out_normal,
  input wire logic [n_out-1:0] out_latched,
  input wire logic [n_out-1:0] out_hold_run,
  input wire logic boot_done,
  input wire logic prot_running,
  input wire logic [1:0] rot_calc,
  input wire logic [1:0] rot_set,
  input wire logic [ana_w-1:0] temp_live,
  input wire logic [ana_w-1:0] aout_assigned,
  input wire logic [ana_w-1:0] ain_live,
  output logic [n_out-1:0] relay_out,
  output logic health_green,
  output logic rot_mismatch,
  output logic reboot_req,
  output logic [ana_w-1:0] temp_value,
  output logic [ana_w-1:0] aout_value,
  output logic [ana_w-1:0] ain_value
);

  // ****************
  // helpers
  // ****************
  function automatic logic timer_next_run(input ovr_e st,
                                          input logic [tmo_w-1:0] cnt);
    timer_next_run = (st == ov_perm) || (st == ov_timed && cnt != '0);
  endfunction

  function automatic logic [n_out-1:0] grp_mask(input int g);
    grp_mask = n_out'({grp_w{1'b1}}) << (g * grp_w);
  endfunction

  // ****************
  // input synchronisers
  // ****************
  logic [n_out*2+6:0] pin_s1_r;
  logic [n_out*2+6:0] pin_s2_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end else begin
      pin_s1_r <= {out_latched, out_hold_run, boot_done, prot_running,
                   rot_calc, rot_set, 1'b0};
      pin_s2_r <= pin_s1_r;
    end
  end
  logic [n_out-1:0] latched_s;
  logic [n_out-1:0] hold_s;
  logic boot_s;
  logic prot_s;
  logic [1:0] rcalc_s;
  logic [1:0] rset_s;
  assign {latched_s, hold_s, boot_s, prot_s, rcalc_s, rset_s} =
    pin_s2_r[n_out*2+6:1];

  // ****************
  // apb access
  // ****************
  logic wr_en;
  logic rd_en;
  assign wr_en = psel && penable && pwrite && pready;
  assign rd_en = psel && !penable && !pwrite;

  logic [31:0] frc_single_r;
  logic [31:0] frc_val_r;
  logic [31:0] frc_grp_r;
  logic [tmo_w-1:0] frc_tmo_r;
  logic [31:0] dis_ctrl_r;
  logic [tmo_w-1:0] dis_tmo_r;
  logic [31:0] ana_ctrl_r [n_ana];
  logic [ana_w-1:0] ana_val_r [n_ana];
  logic [tmo_w-1:0] ana_tmo_r [n_ana];

  logic frc_apply_p;
  logic dis_apply_p;
  logic [n_ana-1:0] ana_apply_p;
  logic frc_wd;
  logic dis_wd;
  logic [n_ana-1:0] ana_wd;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frc_single_r <= rst_zero;
      frc_val_r <= rst_zero;
      frc_grp_r <= rst_zero;
      frc_tmo_r <= '0;
      dis_ctrl_r <= rst_zero;
      dis_tmo_r <= '0;
    end else if (wr_en) begin
      case (paddr)
        a_frc_single: frc_single_r <= pwdata;
        a_frc_val: frc_val_r <= pwdata;
        a_frc_grp: frc_grp_r <= pwdata;
        a_frc_tmo: frc_tmo_r <= pwdata;
        a_dis_ctrl: dis_ctrl_r <= pwdata;
        a_dis_tmo: dis_tmo_r <= pwdata;
        default: ;
      endcase
    end
  end

  // apply strobes and withdraw strobes
  // withdraw only once neither single nor group force is left
  assign frc_apply_p = wr_en && ((paddr == a_frc_single && pwdata != '0) ||
    (paddr == a_frc_grp && pwdata[n_grp-1:0] != '0));
  assign frc_wd = wr_en && ((paddr == a_frc_single && pwdata == '0 &&
    frc_grp_r[n_grp-1:0] == '0) || (paddr == a_frc_grp &&
    pwdata[n_grp-1:0] == '0 && frc_single_r == '0));
  assign dis_apply_p = wr_en && paddr == a_dis_ctrl && pwdata[b_apply];
  assign dis_wd = wr_en && paddr == a_dis_ctrl && !pwdata[b_apply];

  // ****************
  // reboot pulse
  // ****************
  logic [3:0] reboot_cnt_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reboot_cnt_r <= '0;
      reboot_req <= 1'b0;
    end else begin
      if (wr_en && paddr == a_ctrl && pwdata[b_reboot]) begin
        reboot_cnt_r <= 4'(reboot_cyc);
      end else if (reboot_cnt_r != '0) begin
        reboot_cnt_r <= reboot_cnt_r - 4'h1;
      end
      reboot_req <= (reboot_cnt_r != '0);
    end
  end

  // ****************
  // health and phase rotation
  // ****************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      health_green <= 1'b0;
      rot_mismatch <= 1'b0;
    end else begin
      health_green <= boot_s && prot_s;
      rot_mismatch <= (rcalc_s != rset_s);
    end
  end

  // ****************
  // override timers: force, disarm, then one per analog channel
  // ****************
  logic [n_ana+1:0] tmr_apply;
  logic [n_ana+1:0] tmr_wd;
  logic [n_ana+1:0] tmr_perm;
  logic [n_ana+1:0] tmr_on;
  logic [tmo_w-1:0] tmr_load [n_ana+2];
  assign tmr_apply = {ana_apply_p, dis_apply_p, frc_apply_p};
  assign tmr_wd = {ana_wd, dis_wd, frc_wd};
  assign tmr_perm[0] = (paddr == a_frc_single) ? pwdata[b_perm] :
    (pwdata[b_gperm +: n_grp] != '0);
  assign tmr_perm[1] = pwdata[b_perm];
  assign tmr_load[0] = frc_tmo_r;
  assign tmr_load[1] = dis_tmo_r;

  genvar t;
  generate
    for (t = 0; t < n_ana + 2; t++) begin : g_tmr
      ovr_e st_r;
      logic [tmo_w-1:0] cnt_r;
      assign tmr_on[t] = timer_next_run(st_r, cnt_r);
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          st_r <= ov_idle;
          cnt_r <= '0;
        end else if (tmr_apply[t]) begin
          st_r <= tmr_perm[t] ? ov_perm : ov_timed;
          cnt_r <= tmr_load[t];
        end else if (tmr_wd[t]) begin
          st_r <= ov_idle;
          cnt_r <= '0;
        end else begin
          case (st_r)
            ov_timed: begin
              if (cnt_r == '0) st_r <= ov_idle;
              else cnt_r <= cnt_r - 1'b1;
            end
            ov_perm: ;
            ov_idle: ;
            default: st_r <= ov_idle;
          endcase
        end
      end
    end
  endgenerate

  // ****************
  // output resolution
  // ****************
  logic frc_active;
  logic dis_active;
  assign frc_active = tmr_on[0];
  assign dis_active = tmr_on[1];

  logic [n_out-1:0] disarmed_r;
  logic [n_out-1:0] dis_req;
  logic [n_out-1:0] grp_sel;
  logic [n_out-1:0] grp_v;
  always_comb begin
    dis_req = '0;
    grp_sel = '0;
    grp_v = '0;
    for (int g = 0; g < n_grp; g++) begin
      if (dis_active && dis_ctrl_r[b_dis_en + g]) begin
        dis_req = dis_req | grp_mask(g);
      end
      if (frc_grp_r[g]) begin
        grp_sel = grp_sel | grp_mask(g);
        if (frc_grp_r[b_gval + g]) begin
          grp_v = grp_v | grp_mask(g);
        end
      end
    end
    dis_req = dis_req & ~never_disarm;
  end

  // an output enters disarm only while quiet; release is immediate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disarmed_r <= '0;
    end else begin
      disarmed_r <= dis_req & (disarmed_r | (~latched_s & ~hold_s));
    end
  end

  logic [n_out-1:0] frc_sel;
  logic [n_out-1:0] frc_v;
  assign frc_sel = frc_active ? (grp_sel | frc_single_r[n_out-1:0])
    : '0;
  assign frc_v = (grp_sel & grp_v) |
    (~grp_sel & frc_val_r[n_out-1:0]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      relay_out <= '0;
    end else begin
      relay_out <= ~disarmed_r & ((frc_sel & frc_v) |
        (~frc_sel & out_normal));
    end
  end

  // ****************
  // analog forcing channels
  // ****************
  logic [ana_w-1:0] live [n_ana];
  logic [ana_w-1:0] view_r [n_ana];
  logic [ana_w-1:0] aval_r [n_ana];
  assign live[ch_temp] = temp_live;
  assign live[ch_aout] = aout_assigned;
  assign live[ch_ain] = ain_live;

  genvar c;
  generate
    for (c = 0; c < n_ana; c++) begin : g_ana
      logic [11:0] base;
      logic on;
      assign base = a_ana_base + 12'(c) * ana_stride;
      assign ana_apply_p[c] = wr_en && paddr == base + ana_ctrl &&
        pwdata[b_apply];
      assign ana_wd[c] = wr_en && paddr == base + ana_ctrl &&
        !pwdata[b_apply];
      assign on = tmr_on[2 + c];
      assign tmr_perm[2 + c] = pwdata[b_perm];
      assign tmr_load[2 + c] = ana_tmo_r[c];
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ana_ctrl_r[c] <= rst_zero;
          ana_val_r[c] <= '0;
          ana_tmo_r[c] <= '0;
        end else if (wr_en) begin
          if (paddr == base + ana_ctrl) ana_ctrl_r[c] <= pwdata;
          if (paddr == base + ana_val) ana_val_r[c] <= pwdata[ana_w-1:0];
          if (paddr == base + ana_tmo) ana_tmo_r[c] <= pwdata;
        end
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          view_r[c] <= '0;
          aval_r[c] <= '0;
        end else begin
          // view freezes while forcing, live otherwise
          if (!on) view_r[c] <= live[c];
          aval_r[c] <= on ? ana_val_r[c] : live[c];
        end
      end
    end
  endgenerate

  assign temp_value = aval_r[ch_temp];
  assign aout_value = aval_r[ch_aout];
  assign ain_value = aval_r[ch_ain];

  // ****************
  // read mux
  // ****************
  logic [31:0] rd_nxt;
  always_comb begin
    rd_nxt = '0;
    case (paddr)
      a_status: rd_nxt = {26'h0, dis_active, frc_active, rot_mismatch,
        health_green, boot_s, prot_s};
      a_frc_single: rd_nxt = frc_single_r;
      a_frc_val: rd_nxt = frc_val_r;
      a_frc_grp: rd_nxt = frc_grp_r;
      a_frc_tmo: rd_nxt = frc_tmo_r;
      a_dis_ctrl: rd_nxt = dis_ctrl_r;
      a_dis_tmo: rd_nxt = dis_tmo_r;
      a_out_state: rd_nxt = {16'h0, disarmed_r, relay_out};
      default: begin
        for (int k = 0; k < n_ana; k++) begin
          if (paddr == a_ana_base + 12'(k) * ana_stride + ana_ctrl)
            rd_nxt = ana_ctrl_r[k];
          if (paddr == a_ana_base + 12'(k) * ana_stride + ana_val)
            rd_nxt = 32'(ana_val_r[k]);
          if (paddr == a_ana_base + 12'(k) * ana_stride + ana_tmo)
            rd_nxt = ana_tmo_r[k];
          if (paddr == a_ana_base + 12'(k) * ana_stride + ana_view)
            rd_nxt = 32'(view_r[k]);
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (rd_en) prdata <= rd_nxt;
    end
  end

endmodule
`default_nettype wire

// >>> ovr_ctrl_asserts.sv
// port checker for the override block.
// assumes one pclk domain, bound to every ovr_ctrl.
`timescale 1ns/1ns
`default_nettype none
module ovr_ctrl_asserts
  import ovr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic boot_done,
  input wire logic prot_running,
  input wire logic [1:0] rot_calc,
  input wire logic [1:0] rot_set,
  input wire logic health_green,
  input wire logic rot_mismatch,
  input wire logic reboot_req
);
  // *****
  // properties
  // *****
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  health_on_a: assert property ((boot_done && prot_running)[*5]
    |=> health_green) else $error("health lamp not lit");
  health_off_a: assert property ((!boot_done)[*5]
    |=> !health_green) else $error("health lamp lit in boot");
  rot_on_a: assert property ((rot_calc != rot_set)[*5]
    |=> rot_mismatch) else $error("rotation mismatch missed");
  rot_off_a: assert property ((rot_calc == rot_set)[*5]
    |=> !rot_mismatch) else $error("false rotation mismatch");
  setup_ready_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_once_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  no_err_a: assert property (!pslverr) else $error("slave error raised");
  reboot_pulse_a: assert property (psel && penable && pready && pwrite
    && paddr == a_ctrl && pwdata[b_reboot] |-> ##[1:20] reboot_req)
    else $error("reboot not requested");
  unmapped_read_a: assert property (psel && penable && pready && !pwrite
    && paddr >= 12'h080 |-> prdata == 32'h0)
    else $error("unmapped read not zero");
endmodule
bind ovr_ctrl ovr_ctrl_asserts chk_i (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .boot_done,
  .prot_running, .rot_calc, .rot_set, .health_green, .rot_mismatch,
  .reboot_req);
`default_nettype wire

// >>> ovr_pkg.sv
// package for the service override block: register map, field layout,
// reset values and timing constants.
// assumes a 32-bit apb slave on pclk at 100 MHz.
//
// How it works
// - a service command pulses a whole-unit reboot request output.
// - health lamp steady green only after boot done and protection running.
// - status bit raised while computed phase rotation differs from setting.
// - timed output force holds only while its timer runs, then releases.
// - permanent output force holds until software withdraws it.
// - force one output singly or all outputs of a card group together.
// - group force overrides single-output force on the same output.
// - a disarmed output ignores force commands and stays unswitched.
// - output takes forced state only when not disarmed and force applied.
// - zone interlock and self-supervision outputs are never disarmed.
// - timed disarm holds while timer runs; permanent disarm until withdrawn.
// - disarm only when unlatched, no hold timer, control active, applied.
// - forced sensor value held timed or permanent, then live again.
// - sensor view shows live values, frozen while force mode active.
// - forced analog output held timed or permanent, then assigned value.
// - analog output view shows assigned value, frozen once forcing starts.
// - forced analog input held timed or permanent, then real measurement.
// - analog input view shows fed value, frozen once forcing starts.
// - leaving force mode shows live values again.
package ovr_pkg;
  localparam int n_out = 8;
  localparam int n_grp = 2;
  localparam int grp_w = 4;
  localparam int n_ana = 3;
  localparam int ana_w = 16;
  localparam int tmo_w = 32;

  // analog channel indices
  localparam int ch_temp = 0;
  localparam int ch_aout = 1;
  localparam int ch_ain = 2;

  localparam logic [11:0] a_ctrl = 12'h000;
  localparam logic [11:0] a_status = 12'h004;
  localparam logic [11:0] a_frc_single = 12'h008;
  localparam logic [11:0] a_frc_val = 12'h00c;
  localparam logic [11:0] a_frc_grp = 12'h010;
  localparam logic [11:0] a_frc_tmo = 12'h014;
  localparam logic [11:0] a_dis_ctrl = 12'h018;
  localparam logic [11:0] a_dis_tmo = 12'h01c;
  localparam logic [11:0] a_out_state = 12'h020;
  localparam logic [11:0] a_ana_base = 12'h040;

  // per analog channel: ctrl, force value, timeout, view (stride 16)
  localparam logic [11:0] ana_stride = 12'h010;
  localparam logic [11:0] ana_ctrl = 12'h000;
  localparam logic [11:0] ana_val = 12'h004;
  localparam logic [11:0] ana_tmo = 12'h008;
  localparam logic [11:0] ana_view = 12'h00c;

  // ctrl bits
  localparam int b_reboot = 0;
  // force / disarm ctrl fields: [0] apply, [1] permanent
  localparam int b_apply = 0;
  localparam int b_perm = 1;
  // disarm ctrl: [2+g] disarm control active per group
  localparam int b_dis_en = 2;
  // group force: [g] apply group g, [8+g] permanent, [16+] values
  localparam int b_gperm = 8;
  localparam int b_gval = 16;

  // positions of outputs that may never be disarmed
  localparam logic [n_out-1:0] never_disarm = 8'h03;

  localparam logic [31:0] rst_zero = 32'h0000_0000;
  localparam int reboot_ns = 100;
  localparam int clk_ns = 10;
  localparam int reboot_cyc = (reboot_ns + clk_ns - 1) / clk_ns;

  typedef enum logic [1:0] {
    ov_idle = 2'b00,
    ov_timed = 2'b01,
    ov_perm = 2'b11
  } ovr_e;
endpackage

// >>> relay_load_model.sv
// far-side model of the contacts: latch and t-off hold feedback.
// assumes relay_out is registered on pclk.
`timescale 1ns/1ns
`default_nettype none
module relay_load_model
  import ovr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [n_out-1:0] relay_out,
  input wire logic [n_out-1:0] latch_cmd,
  output logic [n_out-1:0] out_latched,
  output logic [n_out-1:0] out_hold_run
);
  // *****
  // hold pulse after a contact drops
  // *****
  logic [n_out-1:0] prev_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_r <= '0;
      out_hold_run <= '0;
      out_latched <= '0;
    end else begin
      prev_r <= relay_out;
      out_hold_run <= prev_r & ~relay_out;
      out_latched <= latch_cmd;
    end
  end
endmodule
`default_nettype wire
